// ### dv/cpd_checker.sv
`timescale 1ns/1ns
module cpd_checker #(
    parameter int SCLK_HALF_CYC = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link wires
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi
);
    logic       sclk_q;
    logic [7:0] run;
    logic [7:0] nbit;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // length of the streak of the current sclk level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
            run    <= 8'h00;
        end else begin
            sclk_q <= sclk;
            run    <= (sclk != sclk_q) ? 8'h01 : run + 8'h01;
        end
    end

    // sclk rises seen inside the current selection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nbit <= 8'h00;
        end else if (cs_n) begin
            nbit <= 8'h00;
        end else if (sclk && !sclk_q) begin
            nbit <= nbit + 8'h01;
        end
    end

    property p_idle_clk;
        cs_n |-> !sclk;
    endproperty
    a_idle_clk: assert property (p_idle_clk)
        else $error("sclk high while deselected");

    property p_sdi_hold;
        sclk |-> $stable(sdi);
    endproperty
    a_sdi_hold: assert property (p_sdi_hold)
        else $error("sdi moved while sclk high");

    property p_high_len;
        $fell(sclk) |-> run == SCLK_HALF_CYC;
    endproperty
    a_high_len: assert property (p_high_len)
        else $error("sclk high phase has wrong length");

    property p_low_len;
        $rose(sclk) && nbit[2:0] != 3'h0 |-> run == SCLK_HALF_CYC;
    endproperty
    a_low_len: assert property (p_low_len)
        else $error("sclk low phase inside a byte has wrong length");

    property p_whole_bytes;
        $rose(cs_n) |-> nbit[2:0] == 3'h0 && nbit != 8'h00;
    endproperty
    a_whole_bytes: assert property (p_whole_bytes)
        else $error("selection ended on a partial byte");

    // the bench runs the host with a half period of 4 cycles
    property p_start_gap;
        $fell(cs_n) |-> !sclk [*4] ##1 sclk;
    endproperty
    a_start_gap: assert property (p_start_gap)
        else $error("first sclk rise not one half period after select");

    property p_end_gap;
        $rose(cs_n) |-> !sclk && run == SCLK_HALF_CYC;
    endproperty
    a_end_gap: assert property (p_end_gap)
        else $error("deselect not one half period after last fall");

    property p_rise_sel;
        $rose(sclk) |-> !cs_n && !$past(cs_n);
    endproperty
    a_rise_sel: assert property (p_rise_sel)
        else $error("sclk rose without a standing selection");
endmodule

// ### dv/cpd_tb.sv
`timescale 1ns/1ns
module cpd_tb;
    import cpd_pkg::*;
    localparam int H = 4;
    // clock, reset, register port
    logic                          clk = 1'b0;
    logic                          rst_n = 1'b0;
    logic [1:0]                    addr = 2'h0;
    logic [REG_W-1:0]              wdata = 32'h0;
    logic                          wr = 1'b0;
    logic                          rd = 1'b0;
    logic [REG_W-1:0]              rdata;
    logic                          id_hi = 1'b0;
    logic                          id_lo = 1'b1;
    // device side
    cpd_smp_t [NUM_DEC-1:0]        dec_smp = 64'h0;
    logic [NUM_DEC-1:0]            dec_smp_vld = 4'h0;
    cpd_db_t [NUM_CH-1:0]          ch_gain_db;
    cpd_mask_t [NUM_CH-1:0]        ch_mix_mask;
    logic [NUM_CH-1:0]             ch_is_decode;
    cpd_smp_t [NUM_DEC-1:0]        ec_ref;
    logic                          proc_halt;
    logic                          pll_en;
    logic                          slow_clk_sel;
    logic                          algo_reset;
    logic                          pd_tick;
    int                            n_mismatch = 0;
    int                            tests_run = 0;
    int                            n_ar = 0;
    int                            n_tick = 0;
    int                            t0;
    logic [7:0]                    seq[$];
    logic [REG_W-1:0]              s;

    cpd_if link();
    cpd_host #(.SCLK_HALF_CYC(H)) i_cpd_host (.clk(clk), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .link(link));
    cpd_dev #(.PD_TICK_CYC(16)) i_cpd_dev (.clk(clk), .rst_n(rst_n),
        .link(link), .chip_id_high_pin(id_hi), .chip_id_low_pin(id_lo),
        .dec_smp(dec_smp), .dec_smp_vld(dec_smp_vld),
        .ch_gain_db(ch_gain_db), .ch_mix_mask(ch_mix_mask),
        .ch_is_decode(ch_is_decode), .ec_ref(ec_ref),
        .proc_halt(proc_halt), .pll_en(pll_en),
        .slow_clk_sel(slow_clk_sel), .algo_reset(algo_reset),
        .pd_tick(pd_tick));
    cpd_checker #(.SCLK_HALF_CYC(H)) i_cpd_checker (.clk(clk),
        .rst_n(rst_n), .sclk(link.sclk), .cs_n(link.cs_n), .sdi(link.sdi));

    always #2 clk = ~clk;

    always @(posedge clk) begin
        if (algo_reset === 1'b1) n_ar++;
        if (pd_tick === 1'b1) n_tick++;
    end

    task automatic chk(input string nm, input logic [63:0] seen,
                       input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 s = rdata;
    endtask

    task automatic wait_idle;
        for (int k = 0; k < 200; k++) begin
            rd_reg(HREG_STAT);
            if (s[STAT_BUSY_BIT] === 1'b0) break;
        end
        // a host stuck busy must not slip through as a quiet return
        chk("idle", s[STAT_BUSY_BIT], 1'b0);
    endtask

    task automatic send_seq;
        for (int i = 0; i < seq.size(); i++) begin
            wait_idle();
            wr_reg(HREG_TX, {23'h0, i == seq.size() - 1, seq[i]});
        end
        wait_idle();
        repeat (8) @(posedge clk);
    endtask

    task automatic t_reset;
        chk("gain", 64'(ch_gain_db), 64'h0);
        chk("mask", 64'(ch_mix_mask), 64'h0);
        chk("dir", 64'(ch_is_decode), 64'h0f);
        chk("pwr", {proc_halt, pll_en, slow_clk_sel}, 3'b010);
        rd_reg(2'h2);
        chk("unmapped", s, 32'h0);
    endtask

    task automatic t_conf;
        seq = '{{CONF_TAG, 2'b01}, 8'h02, 8'h70, 8'h14, 8'h94, 8'h56,
                8'he5, 8'h60, 8'h00, 8'h00};
        send_seq();
        chk("gain", 64'(ch_gain_db), 64'({DB_0, DB_0, DB_0, DB_M6,
            DB_M12, DB_P6, DB_0, DB_0}));
        chk("mask", 64'(ch_mix_mask), 64'h0000_0070_1817_0000);
        seq = '{{CONF_TAG, 2'b01}, 8'h00, 8'hf1, 8'h23};
        send_seq();
        chk("gain0", 64'(ch_gain_db[0]), 64'(DB_M6));
        chk("mask0", 64'(ch_mix_mask[0]), 64'h0f);
        chk("mask2", 64'(ch_mix_mask[2]), 64'h17);
        // foreign id: the whole sequence is dropped
        seq = '{{CONF_TAG, 2'b10}, 8'h00, 8'h40, 8'h00};
        send_seq();
        chk("gain0", 64'(ch_gain_db[0]), 64'(DB_M6));
        chk("mask0", 64'(ch_mix_mask[0]), 64'h0f);
        // the same header is ours once the id pins read 10
        id_hi <= 1'b1;
        id_lo <= 1'b0;
        send_seq();
        chk("gain0", 64'(ch_gain_db[0]), 64'(DB_P6));
        chk("mask0", 64'(ch_mix_mask[0]), 64'h00);
        id_hi <= 1'b0;
        id_lo <= 1'b1;
        // nibbles 8..15 add nothing; the entry past channel 7 is dropped
        seq = '{{CONF_TAG, 2'b01}, 8'h07, 8'h78, 8'h9a, 8'hf1, 8'h23};
        send_seq();
        chk("gain7", 64'(ch_gain_db[7]), 64'(DB_P6));
        chk("mask7", 64'(ch_mix_mask[7]), 64'h80);
        chk("gain0", 64'(ch_gain_db[0]), 64'(DB_P6));
        chk("mask0", 64'(ch_mix_mask[0]), 64'h00);
    endtask

    task automatic t_power;
        wait_idle();
        wr_reg(HREG_TX, {24'h0, PWRDN_TAG, 2'b11});
        wr_reg(HREG_TX, 32'h0);
        rd_reg(HREG_STAT);
        chk("ovr", s[2:1], 2'b11);
        wr_reg(HREG_STAT, 32'h4);
        rd_reg(HREG_STAT);
        chk("ovr", s[STAT_OVR_BIT], 1'b0);
        seq = '{8'h00};
        send_seq();
        chk("pwr", {proc_halt, pll_en, slow_clk_sel}, 3'b010);
        seq = '{{PWRDN_TAG, 2'b01}};
        send_seq();
        chk("pwr", {proc_halt, pll_en, slow_clk_sel}, 3'b101);
        @(negedge clk);
        t0 = n_tick;
        repeat (64) @(negedge clk);
        chk("ticks", n_tick - t0, 4);
        @(negedge clk);
        t0 = n_ar;
        seq = '{{PWRUP_TAG, 2'b01}};
        send_seq();
        @(negedge clk);
        chk("rst_len", n_ar - t0, ALGO_RST_CYC);
        chk("pwr", {proc_halt, pll_en, slow_clk_sel}, 3'b010);
    endtask

    task automatic t_ecref;
        @(posedge clk);
        dec_smp     <= 64'ha5a5_5a5a_1234_8001;
        dec_smp_vld <= 4'hf;
        @(posedge clk);
        dec_smp_vld <= 4'h0;
        dec_smp     <= 64'hffff_eeee_dddd_cccc;
        repeat (3) @(posedge clk);
        chk("ecref", ec_ref, 64'ha5a5_5a5a_1234_8001);
        dec_smp_vld <= 4'h2;
        @(posedge clk);
        dec_smp_vld <= 4'h0;
        repeat (3) @(posedge clk);
        chk("ecref", ec_ref, 64'ha5a5_5a5a_dddd_8001);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // a hung handshake ends the run here
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_conf();
        t_power();
        t_ecref();
        give_verdict();
    end
endmodule

// ### rtl/cpd_dev.sv
`timescale 1ns/1ns
module cpd_dev #(
    parameter int PD_TICK_CYC = cpd_pkg::PD_TICK_CYC
) (
    // clock and reset
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    // command link
    cpd_if.dev                                       link,
    // chip id straps
    input  wire logic                                chip_id_high_pin,
    input  wire logic                                chip_id_low_pin,
    // decode channel output samples
    input  cpd_pkg::cpd_smp_t [cpd_pkg::NUM_DEC-1:0] dec_smp,
    input  wire logic [cpd_pkg::NUM_DEC-1:0]         dec_smp_vld,
    // channel configuration
    output cpd_pkg::cpd_db_t  [cpd_pkg::NUM_CH-1:0]  ch_gain_db,
    output cpd_pkg::cpd_mask_t [cpd_pkg::NUM_CH-1:0] ch_mix_mask,
    output logic [cpd_pkg::NUM_CH-1:0]               ch_is_decode,
    output cpd_pkg::cpd_smp_t [cpd_pkg::NUM_DEC-1:0] ec_ref,
    // power control
    output logic                                     proc_halt,
    output logic                                     pll_en,
    output logic                                     slow_clk_sel,
    output logic                                     algo_reset,
    output logic                                     pd_tick
);
    import cpd_pkg::*;

    // sync order: {id_hi, id_lo, sclk, cs_n, sdi}
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic        sclk_d;
    logic        cs_d;
    logic        sclk_rise;
    logic        cs_rise;
    logic        cs_act;
    logic [1:0]  my_id;
    logic [7:0]  rx_sh;
    logic [2:0]  bit_cnt;
    logic        byte_vld;
    cpd_dst_t    state;
    logic [3:0]  ptr;
    logic [7:0]  hi_byte;
    logic        id_ok;
    logic        pu_cmd;
    logic        pd_cmd;
    logic        entry_done;
    logic [$clog2(ALGO_RST_CYC+1)-1:0] rst_cnt;
    logic [$clog2(PD_TICK_CYC+1)-1:0]  pd_cnt;

    function automatic cpd_db_t gain_db(input logic [1:0] code);
        cpd_db_t g;
        g = DB_0;
        case (code)
            GAIN_P6:  g = DB_P6;
            GAIN_M12: g = DB_M12;
            GAIN_M6:  g = DB_M6;
            default:  g = DB_0;
        endcase
        return g;
    endfunction

    // nibbles 8..15 name no channel and add nothing to the mix
    function automatic cpd_mask_t mix_of(input logic [2:0] self,
                                         input logic [1:0] mode,
                                         input logic [3:0] s1,
                                         input logic [3:0] s2,
                                         input logic [3:0] s3);
        cpd_mask_t m;
        m = MASK_RST;
        if (mode != MODE_OFF) begin
            m[self] = 1'b1;
            if (!s1[3]) begin
                m[s1[2:0]] = 1'b1;
            end
        end
        if ((mode == MODE_TWO || mode == MODE_THREE) && !s2[3]) begin
            m[s2[2:0]] = 1'b1;
        end
        if (mode == MODE_THREE && !s3[3]) begin
            m[s3[2:0]] = 1'b1;
        end
        return m;
    endfunction

    // link pins and straps come from outside this clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 5'h03;
            sync2 <= 5'h03;
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
        end else begin
            sync1 <= {chip_id_high_pin, chip_id_low_pin,
                      link.sclk, link.cs_n, link.sdi};
            sync2 <= sync1;
            sclk_d <= sync2[2];
            cs_d <= sync2[1];
        end
    end

    assign my_id     = sync2[4:3];
    assign cs_act    = !sync2[1];
    assign sclk_rise = sync2[2] && !sclk_d;
    assign cs_rise   = sync2[1] && !cs_d;

    // byte assembly, msb first, taken on each sclk rise while selected
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sh <= 8'h00;
            bit_cnt <= 3'h0;
            byte_vld <= 1'b0;
        end else begin
            byte_vld <= 1'b0;
            if (!cs_act) begin
                bit_cnt <= 3'h0;
            end else if (sclk_rise) begin
                rx_sh <= {rx_sh[6:0], sync2[0]};
                bit_cnt <= bit_cnt + 3'h1;
                byte_vld <= (bit_cnt == 3'h7);
            end
        end
    end

    assign id_ok  = (rx_sh[1:0] == my_id);
    assign pu_cmd = byte_vld && state == D_HDR && id_ok
                    && rx_sh[7:2] == PWRUP_TAG;
    assign pd_cmd = byte_vld && state == D_HDR && id_ok
                    && rx_sh[7:2] == PWRDN_TAG;
    assign entry_done = byte_vld && state == D_LO;

    // sequence walker; deselect always returns to header
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= D_HDR;
            ptr <= 4'h0;
            hi_byte <= 8'h00;
        end else if (cs_rise) begin
            state <= D_HDR;
        end else if (byte_vld) begin
            case (state)
                D_HDR: begin
                    if (id_ok && rx_sh[7:2] == CONF_TAG) begin
                        state <= D_BEGIN;
                    end else begin
                        state <= D_SKIP;
                    end
                end
                D_BEGIN: begin
                    ptr <= (rx_sh[7:3] == 5'h00) ? {1'b0, rx_sh[2:0]}
                                                 : 4'h8;
                    state <= D_HI;
                end
                D_HI: begin
                    hi_byte <= rx_sh;
                    state <= D_LO;
                end
                D_LO: begin
                    if (!ptr[3]) begin
                        ptr <= ptr + 4'h1;
                    end
                    state <= D_HI;
                end
                default: state <= D_SKIP;
            endcase
        end
    end

    // entries past channel 7 are taken but change nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ch_gain_db[i] <= DB_0;
                ch_mix_mask[i] <= MASK_RST;
            end
        end else if (entry_done && !ptr[3]) begin
            ch_gain_db[ptr[2:0]] <= gain_db(hi_byte[7:6]);
            ch_mix_mask[ptr[2:0]] <= mix_of(ptr[2:0], hi_byte[5:4],
                                            hi_byte[3:0], rx_sh[7:4],
                                            rx_sh[3:0]);
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            ch_is_decode[i] = (i < NUM_DEC);
        end
    end

    // decode channel i feeds encode channel i + NUM_DEC
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_DEC; i++) begin
                ec_ref[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_DEC; i++) begin
                if (dec_smp_vld[i]) begin
                    ec_ref[i] <= dec_smp[i];
                end
            end
        end
    end

    // power-up holds processing off while the algorithms reset,
    // then lets it run again; power-down holds it off until power-up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            proc_halt <= 1'b0;
            pll_en <= 1'b1;
            slow_clk_sel <= 1'b0;
            algo_reset <= 1'b0;
            rst_cnt <= '0;
        end else if (pu_cmd) begin
            proc_halt <= 1'b1;
            pll_en <= 1'b1;
            slow_clk_sel <= 1'b0;
            algo_reset <= 1'b1;
            rst_cnt <= ($bits(rst_cnt))'(ALGO_RST_CYC);
        end else if (pd_cmd) begin
            proc_halt <= 1'b1;
            pll_en <= 1'b0;
            slow_clk_sel <= 1'b1;
            algo_reset <= 1'b0;
            rst_cnt <= '0;
        end else if (rst_cnt != '0) begin
            rst_cnt <= rst_cnt - 1'b1;
            if (rst_cnt == 1) begin
                algo_reset <= 1'b0;
                proc_halt <= 1'b0;
            end
        end
    end

    // slow clock rate as an enable pulse while powered down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_cnt <= '0;
            pd_tick <= 1'b0;
        end else if (!slow_clk_sel) begin
            pd_cnt <= '0;
            pd_tick <= 1'b0;
        end else if (pd_cnt == ($bits(pd_cnt))'(PD_TICK_CYC - 1)) begin
            pd_cnt <= '0;
            pd_tick <= 1'b1;
        end else begin
            pd_cnt <= pd_cnt + 1'b1;
            pd_tick <= 1'b0;
        end
    end

endmodule

// ### rtl/cpd_host.sv
`timescale 1ns/1ns
module cpd_host #(
    parameter int SCLK_HALF_CYC = cpd_pkg::SCLK_HALF_CYC
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // register port
    input  wire logic [1:0]                addr,
    input  wire logic [cpd_pkg::REG_W-1:0] wdata,
    input  wire logic                      wr,
    input  wire logic                      rd,
    output logic [cpd_pkg::REG_W-1:0]      rdata,
    // command link
    cpd_if.host                            link
);
    import cpd_pkg::*;

    cpd_hst_t   state;
    logic [7:0] sh;
    logic [2:0] bit_cnt;
    logic       last;
    logic       phase;
    logic       ovr;
    logic       busy;
    logic       tx_wr;
    logic       tick;
    logic [$clog2(SCLK_HALF_CYC+1)-1:0] cnt;

    // bytes are only taken between sequences or between bytes
    assign busy  = (state == H_SHIFT) || (state == H_END);
    assign tx_wr = wr && addr == HREG_TX;
    assign tick  = (cnt == ($bits(cnt))'(SCLK_HALF_CYC - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (state == H_IDLE || state == H_HOLD || tick) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // data changes while sclk is low; the device takes it on the rise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= H_IDLE;
            sh <= 8'h00;
            bit_cnt <= 3'h0;
            last <= 1'b0;
            phase <= 1'b0;
            link.sclk <= 1'b0;
            link.cs_n <= 1'b1;
            link.sdi <= 1'b0;
        end else begin
            case (state)
                H_IDLE, H_HOLD: begin
                    if (tx_wr) begin
                        sh <= wdata[7:0];
                        last <= wdata[TX_LAST_BIT];
                        bit_cnt <= 3'h0;
                        phase <= 1'b0;
                        link.cs_n <= 1'b0;
                        link.sdi <= wdata[7];
                        state <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (tick && !phase) begin
                        link.sclk <= 1'b1;
                        phase <= 1'b1;
                    end else if (tick) begin
                        link.sclk <= 1'b0;
                        phase <= 1'b0;
                        if (bit_cnt == 3'h7) begin
                            state <= last ? H_END : H_HOLD;
                        end else begin
                            bit_cnt <= bit_cnt + 3'h1;
                            sh <= {sh[6:0], 1'b0};
                            link.sdi <= sh[6];
                        end
                    end
                end
                default: begin
                    // hold select one half period, then idle it one more
                    if (tick && !phase) begin
                        link.cs_n <= 1'b1;
                        phase <= 1'b1;
                    end else if (tick) begin
                        phase <= 1'b0;
                        state <= H_IDLE;
                    end
                end
            endcase
        end
    end

    // overrun: a byte written while busy is dropped; set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr <= 1'b0;
        end else if (tx_wr && busy) begin
            ovr <= 1'b1;
        end else if (wr && addr == HREG_STAT && wdata[STAT_OVR_BIT]) begin
            ovr <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (rd && addr == HREG_STAT) begin
            rdata <= '0;
            rdata[STAT_BUSY_BIT] <= busy;
            rdata[STAT_CS_BIT] <= !link.cs_n;
            rdata[STAT_OVR_BIT] <= ovr;
        end else begin
            rdata <= '0;
        end
    end

endmodule

// ### rtl/cpd_if.sv
`timescale 1ns/1ns
interface cpd_if;
    logic sclk;
    logic cs_n;
    logic sdi;
    modport host (output sclk, output cs_n, output sdi);
    modport dev  (input sclk, input cs_n, input sdi);
endinterface

// ### rtl/cpd_pkg.sv
package cpd_pkg;

    // clock and link timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_HZ        = 250_000_000;
    localparam int SCLK_HALF_NS  = 64;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int ALGO_RST_NS   = 40;
    localparam int ALGO_RST_CYC  = (ALGO_RST_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int PD_CLK_HZ     = 125;
    localparam int PD_TICK_CYC   = CLK_HZ / PD_CLK_HZ;

    // channel layout
    localparam int NUM_CH  = 8;
    localparam int NUM_DEC = 4;
    localparam int SMP_W   = 16;

    // command byte tags, bits [7:2]; bits [1:0] carry the chip id
    localparam logic [5:0] CONF_TAG  = 6'h08;
    localparam logic [5:0] PWRUP_TAG = 6'h04;
    localparam logic [5:0] PWRDN_TAG = 6'h02;

    localparam logic [1:0] GAIN_0DB  = 2'h0;
    localparam logic [1:0] GAIN_P6   = 2'h1;
    localparam logic [1:0] GAIN_M12  = 2'h2;
    localparam logic [1:0] GAIN_M6   = 2'h3;

    localparam logic [1:0] MODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_ONE   = 2'h1;
    localparam logic [1:0] MODE_TWO   = 2'h2;
    localparam logic [1:0] MODE_THREE = 2'h3;

    typedef logic signed [4:0]  cpd_db_t;
    typedef logic [NUM_CH-1:0]  cpd_mask_t;
    typedef logic [SMP_W-1:0]   cpd_smp_t;

    localparam cpd_db_t   DB_0     = 5'h00;
    localparam cpd_db_t   DB_P6    = 5'h06;
    localparam cpd_db_t   DB_M12   = 5'h14;
    localparam cpd_db_t   DB_M6    = 5'h1a;
    localparam cpd_mask_t MASK_RST = 8'h00;

    // host register port
    localparam int         REG_W         = 32;
    localparam logic [1:0] HREG_TX       = 2'h0;
    localparam logic [1:0] HREG_STAT     = 2'h1;
    localparam int         TX_LAST_BIT   = 8;
    localparam int         STAT_BUSY_BIT = 0;
    localparam int         STAT_CS_BIT   = 1;
    localparam int         STAT_OVR_BIT  = 2;

    typedef enum logic [2:0] {
        D_HDR   = 3'h0,
        D_BEGIN = 3'h1,
        D_HI    = 3'h3,
        D_LO    = 3'h2,
        D_SKIP  = 3'h6
    } cpd_dst_t;

    typedef enum logic [1:0] {
        H_IDLE  = 2'h0,
        H_SHIFT = 2'h1,
        H_HOLD  = 2'h3,
        H_END   = 2'h2
    } cpd_hst_t;

endpackage
